// file: status_and_trigger_control.sv
// Status reporting groups and trigger state machine of a signal generator.
// Assumes an outside parser delivering one-cycle command strobes and data.
//
// Contract
// - Operational bits 3,4,5 follow sweeping, measuring and armed.
// - Operational bits 0-2 and 6-15 always read zero.
// - Operational summary drives status byte bit 7.
// - Questionable summary drives status byte bit 3.
// - Questionable bits 3,5,7: unleveled, unlocked, modulation range error.
// - Questionable bits 9,10,11: self-test, sweep lock, oven; rest zero.
// - Power-up, reset command or abort puts trigger machine idle.
// - Idle until initiated; continuous mode initiates automatically.
// - Continuous off: only immediate-initiate moves idle to armed.
// - Armed watches source: immediate true, bus on trigger, hold never.
// - True trigger while armed starts the sweep.
// - Immediate trigger forces one trigger, source left unchanged.
// - Sweep done: idle if continuous off, armed if on.
// - Abort ends sweep, goes idle at once, settings kept.
// - Clear-status clears status byte, events, error queue, pending flag.
// - Standard-event enable 0-255 stored and returned on query.
// - Standard event query returns value then clears it.
// - After operation-complete command, set its bit when pending done.
// - Operation-complete query queues ASCII 1, sets data-available flag.
// - Service-request enable 0-255, zero clears; query bit 6 zero.
// - Status byte query returns bits with bit 6 master summary, no clear.
// - Trigger command triggers only with bus source, like group trigger.
// - Summary is OR of event bits ANDed with enables.
// - Event bits latch filtered transitions, held until query or clear.
`timescale 1ns/1ps
`default_nettype none
module status_and_trigger_control
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_cmd_rst,
  input wire logic i_cmd_cls,
  input wire logic i_cmd_abort,
  input wire logic i_cmd_init_imm,
  input wire logic i_cmd_trig_imm,
  input wire logic i_cmd_trg,
  input wire logic i_get,
  input wire logic i_cmd_opc,
  input wire logic i_cmd_opc_query,
  input wire logic i_cmd_cont_wr,
  input wire logic i_cont_val,
  input wire logic i_cmd_src_wr,
  input wire status_trigger_pkg::trig_src_t i_src_val,
  input wire logic i_cmd_ese_wr,
  input wire logic i_cmd_sre_wr,
  input wire logic [7:0] i_enable_val,
  input wire logic i_cmd_esr_query,
  input wire logic i_cmd_oper_query,
  input wire logic i_cmd_ques_query,
  input wire logic i_cmd_oper_en_wr,
  input wire logic i_cmd_ques_en_wr,
  input wire logic i_cmd_oper_ptr_wr,
  input wire logic i_cmd_oper_ntr_wr,
  input wire logic i_cmd_ques_ptr_wr,
  input wire logic i_cmd_ques_ntr_wr,
  input wire logic i_cmd_preset,
  input wire logic [15:0] i_reg_val,
  input wire logic i_out_read,
  input wire logic i_esr_events,
  input wire logic [7:0] i_esr_set,
  input wire logic i_err_queue_nonempty,
  input wire logic i_ops_pending,
  input wire logic i_sweep_done,
  input wire logic i_measuring,
  input wire logic i_unleveled,
  input wire logic i_unlocked,
  input wire logic i_mod_range_err,
  input wire logic i_selftest_fail,
  input wire logic i_sweep_lock_err,
  input wire logic i_oven_fail,
  output logic o_sweep_start,
  output logic o_sweeping,
  output logic o_armed,
  output logic o_err_queue_clear,
  output logic o_out_valid,
  output logic [7:0] o_out_data,
  output logic [7:0] o_status_byte,
  output logic [7:0] o_ese,
  output logic [7:0] o_sre,
  output logic [7:0] o_esr_read,
  output logic [15:0] o_oper_event,
  output logic [15:0] o_ques_event,
  output logic o_continuous,
  output status_trigger_pkg::trig_src_t o_source
);
  import status_trigger_pkg::*;

  trig_state_t state_r, state_nxt;
  logic cont_r, trig_true;
  trig_src_t src_r;
  logic [15:0] oper_cond, ques_cond;
  logic [15:0] oper_prev_r, ques_prev_r;
  logic [15:0] oper_ev_r, ques_ev_r;
  logic [15:0] oper_en_r, ques_en_r;
  logic [15:0] oper_ptr_r, oper_ntr_r;
  logic [15:0] ques_ptr_r, ques_ntr_r;
  logic [7:0] esr_r, ese_r, sre_r, stb_raw;
  logic opc_pend_r, opcq_pend_r, mav_r, master_summary_flag;

  // Trigger condition for the armed state
  always_comb
  begin
    unique case (src_r)
      SRC_IMM: trig_true = 1'b1;
      SRC_BUS: trig_true = i_get | i_cmd_trg;
      default: trig_true = 1'b0;
    endcase
    if (i_cmd_trig_imm)
      trig_true = 1'b1;
  end

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
        if (cont_r || i_cmd_init_imm)
          state_nxt = ST_ARMED;
      ST_ARMED:
        if (trig_true)
          state_nxt = ST_SWEEP;
      ST_SWEEP:
        if (i_sweep_done)
          state_nxt = cont_r ? ST_ARMED : ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
    if (i_cmd_abort || i_cmd_rst)
      state_nxt = ST_IDLE;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_r <= ST_IDLE;
      o_sweep_start <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      o_sweep_start <= (state_r == ST_ARMED) && (state_nxt == ST_SWEEP);
    end
  end

  // Trigger settings; abort leaves them alone
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cont_r <= 1'b0;
      src_r <= SRC_IMM;
    end
    else if (i_cmd_rst)
    begin
      cont_r <= 1'b0;
      src_r <= SRC_IMM;
    end
    else
    begin
      if (i_cmd_cont_wr)
        cont_r <= i_cont_val;
      if (i_cmd_src_wr)
        src_r <= i_src_val;
    end
  end

  // Condition registers
  always_comb
  begin
    oper_cond = EVT_ZERO;
    oper_cond[OPER_SWEEP_BIT] = (state_r == ST_SWEEP);
    oper_cond[OPER_MEAS_BIT] = i_measuring;
    oper_cond[OPER_ARMED_BIT] = (state_r == ST_ARMED);
    ques_cond = EVT_ZERO;
    ques_cond[QUES_UNLEV_BIT] = i_unleveled;
    ques_cond[QUES_UNLOCK_BIT] = i_unlocked;
    ques_cond[QUES_MODRANGE_BIT] = i_mod_range_err;
    ques_cond[QUES_SELFTEST_BIT] = i_selftest_fail;
    ques_cond[QUES_SWPLOCK_BIT] = i_sweep_lock_err;
    ques_cond[QUES_OVEN_BIT] = i_oven_fail;
  end

  // Filters and enables
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      oper_ptr_r <= PTR_RESET;
      oper_ntr_r <= EVT_ZERO;
      ques_ptr_r <= PTR_RESET;
      ques_ntr_r <= EVT_ZERO;
      oper_en_r <= EVT_ZERO;
      ques_en_r <= EVT_ZERO;
    end
    else if (i_cmd_preset)
    begin
      oper_ptr_r <= PTR_RESET;
      oper_ntr_r <= EVT_ZERO;
      ques_ptr_r <= PTR_RESET;
      ques_ntr_r <= EVT_ZERO;
      oper_en_r <= EVT_ZERO;
      ques_en_r <= EVT_ZERO;
    end
    else
    begin
      if (i_cmd_oper_ptr_wr)
        oper_ptr_r <= i_reg_val;
      if (i_cmd_oper_ntr_wr)
        oper_ntr_r <= i_reg_val;
      if (i_cmd_ques_ptr_wr)
        ques_ptr_r <= i_reg_val;
      if (i_cmd_ques_ntr_wr)
        ques_ntr_r <= i_reg_val;
      if (i_cmd_oper_en_wr)
        oper_en_r <= i_reg_val;
      if (i_cmd_ques_en_wr)
        ques_en_r <= i_reg_val;
    end
  end

  // Event latches; a new event wins over a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      oper_prev_r <= EVT_ZERO;
      ques_prev_r <= EVT_ZERO;
      oper_ev_r <= EVT_ZERO;
      ques_ev_r <= EVT_ZERO;
    end
    else
    begin
      oper_prev_r <= oper_cond;
      ques_prev_r <= ques_cond;
      oper_ev_r <= (((i_cmd_oper_query || i_cmd_cls) ? EVT_ZERO : oper_ev_r)
        | (oper_cond & ~oper_prev_r & oper_ptr_r)
        | (~oper_cond & oper_prev_r & oper_ntr_r)) & OPER_USED_MASK;
      ques_ev_r <= (((i_cmd_ques_query || i_cmd_cls) ? EVT_ZERO : ques_ev_r)
        | (ques_cond & ~ques_prev_r & ques_ptr_r)
        | (~ques_cond & ques_prev_r & ques_ntr_r)) & QUES_USED_MASK;
    end
  end

  // Standard event register, operation complete tracking
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      esr_r <= BYTE_ZERO;
      opc_pend_r <= 1'b0;
      o_esr_read <= BYTE_ZERO;
    end
    else
    begin
      if (i_cmd_esr_query)
        o_esr_read <= esr_r;
      esr_r <= (((i_cmd_esr_query || i_cmd_cls) ? BYTE_ZERO : esr_r)
        | (i_esr_events ? i_esr_set : BYTE_ZERO)
        | ((opc_pend_r && !i_ops_pending) ? 8'h01 << ESR_OPC_BIT
          : BYTE_ZERO)) & ESR_USED_MASK;
      if (i_cmd_cls)
        opc_pend_r <= 1'b0;
      else if (i_cmd_opc)
        opc_pend_r <= 1'b1;
      else if (!i_ops_pending)
        opc_pend_r <= 1'b0;
    end
  end

  // Operation-complete query answer
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      opcq_pend_r <= 1'b0;
      mav_r <= 1'b0;
      o_out_valid <= 1'b0;
      o_out_data <= BYTE_ZERO;
    end
    else
    begin
      o_out_valid <= 1'b0;
      if (i_cmd_opc_query)
        opcq_pend_r <= 1'b1;
      else if (opcq_pend_r && !i_ops_pending)
      begin
        opcq_pend_r <= 1'b0;
        o_out_valid <= 1'b1;
        o_out_data <= ASCII_ONE;
      end
      if (opcq_pend_r && !i_ops_pending && !i_cmd_opc_query)
        mav_r <= 1'b1;
      else if (i_out_read || i_cmd_cls)
        mav_r <= 1'b0;
    end
  end

  // Enable masks
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ese_r <= BYTE_ZERO;
      sre_r <= BYTE_ZERO;
    end
    else
    begin
      if (i_cmd_ese_wr)
        ese_r <= i_enable_val;
      if (i_cmd_sre_wr)
        sre_r <= i_enable_val;
    end
  end

  // Summary status byte
  always_comb
  begin
    stb_raw = BYTE_ZERO;
    stb_raw[STB_ERRQ_BIT] = i_err_queue_nonempty;
    stb_raw[STB_QUES_BIT] = |(ques_ev_r & ques_en_r);
    stb_raw[STB_MAV_BIT] = mav_r;
    stb_raw[STB_ESB_BIT] = |(esr_r & ese_r);
    stb_raw[STB_OPER_BIT] = |(oper_ev_r & oper_en_r);
    master_summary_flag = |(stb_raw & sre_r & ~(8'h01 << STB_MSS_BIT));
    stb_raw[STB_MSS_BIT] = master_summary_flag;
  end

  // Registered outputs
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_status_byte <= BYTE_ZERO;
      o_ese <= BYTE_ZERO;
      o_sre <= BYTE_ZERO;
      o_oper_event <= EVT_ZERO;
      o_ques_event <= EVT_ZERO;
      o_sweeping <= 1'b0;
      o_armed <= 1'b0;
      o_err_queue_clear <= 1'b0;
      o_continuous <= 1'b0;
      o_source <= SRC_IMM;
    end
    else
    begin
      o_status_byte <= stb_raw;
      o_ese <= ese_r;
      o_sre <= sre_r & ~(8'h01 << STB_MSS_BIT);
      o_oper_event <= oper_ev_r;
      o_ques_event <= ques_ev_r;
      o_sweeping <= (state_nxt == ST_SWEEP);
      o_armed <= (state_nxt == ST_ARMED);
      o_err_queue_clear <= i_cmd_cls;
      o_continuous <= cont_r;
      o_source <= src_r;
    end
  end
endmodule
`default_nettype wire

// file: status_and_trigger_control_tb.sv
// Bench: command strobe sequences with expected outputs.
// Assumes the sweep engine model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module status_and_trigger_control_tb;
  import status_trigger_pkg::*;
  logic i_clk, i_rst_b, i_cont_val, i_sweep_done;
  logic [24:0] c;
  logic [8:0] lv;
  logic [7:0] i_enable_val, i_esr_set;
  logic [15:0] i_reg_val, o_oper_event, o_ques_event;
  trig_src_t i_src_val, o_source;
  logic o_sweep_start, o_sweeping, o_armed, o_err_queue_clear;
  logic o_out_valid, o_continuous;
  logic [7:0] o_out_data, o_status_byte, o_ese, o_sre, o_esr_read;
  int failures, num_checks, starts, n0, k;
  wire i_cmd_rst = c[0], i_cmd_cls = c[1], i_cmd_abort = c[2],
    i_cmd_init_imm = c[3], i_cmd_trig_imm = c[4], i_cmd_trg = c[5],
    i_get = c[6], i_cmd_opc = c[7], i_cmd_opc_query = c[8],
    i_cmd_cont_wr = c[9], i_cmd_src_wr = c[10], i_cmd_ese_wr = c[11],
    i_cmd_sre_wr = c[12], i_cmd_esr_query = c[13],
    i_cmd_oper_query = c[14], i_cmd_ques_query = c[15],
    i_cmd_oper_en_wr = c[16], i_cmd_ques_en_wr = c[17],
    i_cmd_oper_ptr_wr = c[18], i_cmd_oper_ntr_wr = c[19],
    i_cmd_ques_ptr_wr = c[20], i_cmd_ques_ntr_wr = c[21],
    i_cmd_preset = c[22], i_out_read = c[23], i_esr_events = c[24];
  wire i_err_queue_nonempty = lv[0], i_ops_pending = lv[1],
    i_measuring = lv[2], i_unleveled = lv[3], i_unlocked = lv[4],
    i_mod_range_err = lv[5], i_selftest_fail = lv[6],
    i_sweep_lock_err = lv[7], i_oven_fail = lv[8];
  status_and_trigger_control status_and_trigger_control_i (.*);
  sweep_engine_model #(.LEN(4)) sweep_engine_model_i (.i_clk(i_clk),
    .i_rst_b(i_rst_b), .i_start(o_sweep_start), .o_done(i_sweep_done));
  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  always @(negedge i_clk)
    if (o_sweep_start === 1'b1)
      starts++;
  task automatic wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic pulse(input int b);
    @(negedge i_clk) c[b] = 1'b1;
    @(negedge i_clk) c[b] = 1'b0;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    c = '0;
    lv = '0;
    i_cont_val = 1'b0;
    i_src_val = SRC_HOLD;
    i_enable_val = 8'hFF;
    i_esr_set = 8'h3C;
    i_reg_val = 16'hFFFF;
    i_rst_b = 1'b0;
    repeat (8) @(posedge i_clk);
    @(negedge i_clk) i_rst_b = 1'b1;
    wt(2);
    chk(o_source, SRC_IMM);
    lv[8:3] = 6'h3F;
    wt(3);
    chk(o_ques_event, QUES_USED_MASK);
    pulse(17);
    wt(3);
    chk(o_status_byte[3], 1);
    pulse(15);
    wt(2);
    chk(o_ques_event, 0);
    pulse(21);
    lv[8:3] = 6'h00;
    wt(3);
    chk(o_ques_event, QUES_USED_MASK);
    pulse(22);
    pulse(15);
    wt(2);
    chk(o_ques_event, 0);
    pulse(16);
    pulse(10);
    lv[2] = 1'b1;
    pulse(3);
    wt(4);
    chk(o_armed, 1);
    pulse(5);
    wt(2);
    chk(o_armed, 1);
    pulse(4);
    chk(o_sweeping, 1);
    chk(o_source, SRC_HOLD);
    wt(8);
    chk({o_armed, o_sweeping}, 0);
    chk(o_oper_event, OPER_USED_MASK);
    chk(o_status_byte[7], 1);
    lv[2] = 1'b0;
    pulse(14);
    wt(2);
    chk(o_oper_event, 0);
    i_src_val = SRC_BUS;
    pulse(10);
    pulse(3);
    pulse(6);
    chk(o_sweeping, 1);
    pulse(2);
    chk({o_armed, o_sweeping}, 0);
    chk(o_source, SRC_BUS);
    pulse(3);
    pulse(5);
    chk(o_sweeping, 1);
    pulse(2);
    i_src_val = SRC_IMM;
    pulse(10);
    i_cont_val = 1'b1;
    n0 = starts;
    pulse(9);
    wt(30);
    chk(starts - n0 >= 2, 1);
    pulse(0);
    wt(2);
    chk({o_armed, o_sweeping, o_continuous}, 0);
    pulse(11);
    pulse(12);
    wt(2);
    chk(o_ese, 8'hFF);
    chk(o_sre, 8'hBF);
    i_enable_val = 8'h00;
    pulse(11);
    pulse(12);
    pulse(24);
    chk({o_ese, o_sre}, 0);
    pulse(13);
    wt(2);
    chk(o_esr_read, 8'h3C);
    pulse(13);
    wt(2);
    chk(o_esr_read, 0);
    lv[1] = 1'b1;
    pulse(7);
    wt(3);
    pulse(13);
    wt(2);
    chk(o_esr_read[0], 0);
    lv[1] = 1'b0;
    wt(3);
    pulse(13);
    wt(2);
    chk(o_esr_read[0], 1);
    i_enable_val = 8'h10;
    pulse(12);
    pulse(8);
    k = 0;
    while (o_out_valid !== 1'b1 && k < 10)
    begin
      @(negedge i_clk);
      k++;
    end
    chk(k < 10, 1);
    if (k == 10)
      summarize();
    chk(o_out_data, 8'h31);
    wt(3);
    chk(o_status_byte[6:4], 3'b101);
    pulse(23);
    wt(3);
    chk(o_status_byte[4], 0);
    i_reg_val = 16'h0000;
    pulse(20);
    pulse(18);
    i_reg_val = 16'hFFFF;
    pulse(19);
    i_src_val = SRC_HOLD;
    pulse(10);
    lv = 9'h1FB;
    pulse(14);
    wt(3);
    chk(o_ques_event, 0);
    pulse(3);
    pulse(2);
    wt(2);
    chk(o_oper_event, 16'h0020);
    pulse(7);
    pulse(24);
    wt(3);
    chk(o_status_byte, 8'h84);
    pulse(1);
    lv[1] = 1'b0;
    wt(3);
    chk(o_ques_event, 0);
    chk(o_status_byte, 8'h04);
    pulse(13);
    wt(2);
    chk(o_esr_read, 0);
    summarize();
  end
endmodule
`default_nettype wire

// file: status_trigger_pkg.sv
// Constants for the status reporting and trigger sequencing block.
// Assumes a command decoder outside that raises one-cycle command strobes.
package status_trigger_pkg;
  localparam int EVT_W = 16;
  localparam int BYTE_W = 8;
  // Operational event bit positions
  localparam int OPER_SWEEP_BIT = 3;
  localparam int OPER_MEAS_BIT = 4;
  localparam int OPER_ARMED_BIT = 5;
  localparam logic [15:0] OPER_USED_MASK = 16'h0038;
  // Questionable event bit positions
  localparam int QUES_UNLEV_BIT = 3;
  localparam int QUES_UNLOCK_BIT = 5;
  localparam int QUES_MODRANGE_BIT = 7;
  localparam int QUES_SELFTEST_BIT = 9;
  localparam int QUES_SWPLOCK_BIT = 10;
  localparam int QUES_OVEN_BIT = 11;
  localparam logic [15:0] QUES_USED_MASK = 16'h0EA8;
  // Summary status byte bit positions
  localparam int STB_ERRQ_BIT = 2;
  localparam int STB_QUES_BIT = 3;
  localparam int STB_MAV_BIT = 4;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_MSS_BIT = 6;
  localparam int STB_OPER_BIT = 7;
  // Standard event bit holding operation complete
  localparam int ESR_OPC_BIT = 0;
  localparam logic [7:0] ESR_USED_MASK = 8'h3D;
  localparam logic [7:0] ASCII_ONE = 8'h31;
  localparam logic [15:0] EVT_ZERO = 16'h0000;
  localparam logic [15:0] PTR_RESET = 16'hFFFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_SWEEP = 3'b100
  } trig_state_t;
  typedef enum logic [1:0]
  {
    SRC_IMM = 2'h0,
    SRC_BUS = 2'h1,
    SRC_HOLD = 2'h2
  } trig_src_t;
endpackage

// file: status_trigger_props.sv
// Checker of block outputs against the command strobes.
// Assumes one clock domain and binding into the block.
`timescale 1ns/1ps
`default_nettype none
module status_trigger_props
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_cmd_rst,
  input wire logic i_cmd_cls,
  input wire logic i_cmd_abort,
  input wire logic i_cmd_init_imm,
  input wire logic i_cmd_trig_imm,
  input wire logic i_cmd_trg,
  input wire logic o_sweep_start,
  input wire logic o_sweeping,
  input wire logic o_armed,
  input wire logic o_err_queue_clear,
  input wire logic [7:0] o_sre,
  input wire logic [15:0] o_oper_event,
  input wire logic [15:0] o_ques_event,
  input wire status_trigger_pkg::trig_src_t o_source
);
  import status_trigger_pkg::*;
  wire q = !i_cmd_abort && !i_cmd_rst;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  property p_oper;
    (o_oper_event & ~OPER_USED_MASK) == EVT_ZERO;
  endproperty
  a_oper: assert property (p_oper) else $error("oper stray bit");
  property p_ques;
    (o_ques_event & ~QUES_USED_MASK) == EVT_ZERO;
  endproperty
  a_ques: assert property (p_ques) else $error("ques stray bit");
  property p_sre;
    o_sre[STB_MSS_BIT] == 1'b0;
  endproperty
  a_sre: assert property (p_sre) else $error("sre bit 6 set");
  property p_idle;
    i_cmd_abort || i_cmd_rst |=> !o_armed && !o_sweeping;
  endproperty
  a_idle: assert property (p_idle) else $error("not idle");
  property p_init;
    i_cmd_init_imm && !o_armed && !o_sweeping && q |=> o_armed;
  endproperty
  a_init: assert property (p_init) else $error("not armed");
  property p_trg;
    i_cmd_trg && o_armed && o_source == SRC_BUS && q |=> o_sweep_start;
  endproperty
  a_trg: assert property (p_trg) else $error("bus trigger lost");
  property p_tim;
    i_cmd_trig_imm && o_armed && q |=> o_sweep_start;
  endproperty
  a_tim: assert property (p_tim) else $error("forced trigger lost");
  property p_cls;
    i_cmd_cls |=> o_err_queue_clear;
  endproperty
  a_cls: assert property (p_cls) else $error("no queue clear");
  c_sweep: cover property (o_sweep_start);
  c_abort: cover property (i_cmd_abort && o_sweeping);
  c_cls: cover property (o_err_queue_clear);
endmodule
bind status_and_trigger_control status_trigger_props status_trigger_props_i
  (.*);
`default_nettype wire

// file: sweep_engine_model.sv
// Far-side sweep engine: ends each started sweep after a fixed run.
// Assumes the start pulse of the block, same clock.
`timescale 1ns/1ps
`default_nettype none
module sweep_engine_model
#(
  parameter int LEN = 4
)
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_start,
  output logic o_done
);
  int cnt_r;
  always_ff @(negedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt_r <= 0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= cnt_r == 1;
      cnt_r <= i_start ? LEN : (cnt_r > 0 ? cnt_r - 1 : 0);
    end
  end
endmodule
`default_nettype wire
